// file: inc/tmr_regs.svh
// Offsets, control byte fields, reset values and timing for the timer.
// Assumes an 8-bit register port with 5 address bits behind a base.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
// Byte offsets from the base
`define TMR_OFS_CTR0   5'h14
`define TMR_OFS_CTR1   5'h15
`define TMR_OFS_CTR2   5'h16
`define TMR_OFS_CTRL   5'h17
`define TMR_OFS_GATE   5'h1E
// Control byte fields
`define TMR_SEL_HI     7
`define TMR_SEL_LO     6
`define TMR_ACC_HI     5
`define TMR_ACC_LO     4
`define TMR_MODE_HI    3
`define TMR_MODE_LO    1
`define TMR_BCD_BIT    0
// Read-back command fields
`define TMR_RB_LATCH   5
`define TMR_RB_STAT    4
`define TMR_RB_PICK0   1
// Codes
`define TMR_SEL_RB     2'h3
`define TMR_ACC_LATCH  2'h0
`define TMR_ACC_LO_B   2'h1
`define TMR_ACC_HI_B   2'h2
`define TMR_ACC_PAIR   2'h3
// Reset values
`define TMR_GATE_RST   1'b0
`define TMR_ACC_RST    2'h1
// Counting source and system clock, in kHz
`define TMR_SRC_KHZ    18'd10000
`define TMR_SYS_KHZ    18'd125000
`endif

// file: inc/tmr_pkg.sv
// Types shared by the timer top and its counting core.
// Assumes nothing beyond a SystemVerilog compiler.
package tmr_pkg;
  // Decoded operating mode, one-hot
  typedef enum logic [5:0] {
    MODE_TC       = 6'b000001,
    MODE_ONESHOT  = 6'b000010,
    MODE_RATE     = 6'b000100,
    MODE_SQUARE   = 6'b001000,
    MODE_SWSTROBE = 6'b010000,
    MODE_HWSTROBE = 6'b100000
  } mode_type;
endpackage

// file: rtl/tmr_core.sv
// One 16-bit presettable down counter with six modes.
// Assumes tick, gate and strobes are all on clk; tick is a one-cycle pulse.
`timescale 1ns/1ps
module tmr_core (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic              gate,
  input  wire logic              cfg_wr,
  input  wire tmr_pkg::mode_type mode,
  input  wire logic              bcd,
  input  wire logic              load,
  input  wire logic [15:0]       load_val,
  output logic      [15:0]       count,
  output logic                   out,
  output logic                   null_cnt
);
  logic [16:0] cnt_q;   // Extra bit lets square wave hold N+1
  logic [15:0] init_q;  // Count register
  logic        out_q;   // Output level
  logic        run_q;   // Counting element active
  logic        ld_q;    // New count waiting for transfer
  logic        null_q;  // Count not yet in counting element
  logic        gate_q;  // Previous gate level
  logic        trig_q;  // Gate rise waiting for next tick
  logic        armed;   // A count exists to trigger on
  logic [16:0] cnt_dec; // Count less one
  logic [16:0] init_w;  // Count register widened

  // Decrement by one, per nibble in decimal
  function automatic logic [15:0] dec1(input logic [15:0] v, input logic b);
    logic [15:0] r;
    logic        brw;
    r   = v;
    brw = 1'b1;
    if (!b) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (brw) begin
          if (r[i*4+:4] == 4'h0) begin
            r[i*4+:4] = 4'h9;
          end else begin
            r[i*4+:4] = r[i*4+:4] - 4'h1;
            brw       = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  assign cnt_dec  = {1'b0, dec1(cnt_q[15:0], bcd)};
  assign init_w   = {1'b0, init_q};
  assign armed    = ld_q | ~null_q;
  assign count    = cnt_q[15:0];
  assign out      = out_q;
  assign null_cnt = null_q;

  // Gate rising edge, held until the next count pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      gate_q <= gate;
      if (gate & ~gate_q) begin
        trig_q <= 1'b1; // Set wins over the tick that consumes it
      end else if (tick) begin
        trig_q <= 1'b0;
      end
    end
  end

  // Counting element and output; a load in a tick cycle eats that tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 17'h00000;
      init_q <= 16'h0000;
      out_q  <= 1'b1;
      run_q  <= 1'b0;
      ld_q   <= 1'b0;
      null_q <= 1'b1;
    end else if (cfg_wr) begin
      out_q  <= (mode != tmr_pkg::MODE_TC);
      run_q  <= 1'b0;
      ld_q   <= 1'b0;
      null_q <= 1'b1;
    end else if (load) begin
      init_q <= load_val;
      ld_q   <= 1'b1;
      null_q <= 1'b1;
      if (mode == tmr_pkg::MODE_TC) begin
        out_q <= 1'b0;
      end
    end else if (tick) begin
      case (mode)
        tmr_pkg::MODE_TC: begin
          if (ld_q) begin
            cnt_q  <= init_w;
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            run_q  <= 1'b1;
          end else if (run_q && gate) begin
            cnt_q <= cnt_dec;
            if (cnt_q[15:0] == 16'h0001) begin
              out_q <= 1'b1;
            end
          end
        end
        tmr_pkg::MODE_ONESHOT: begin
          if (trig_q && armed) begin
            cnt_q  <= init_w;
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            out_q  <= 1'b0;
            run_q  <= 1'b1;
          end else if (run_q) begin
            cnt_q <= cnt_dec;
            if (cnt_q[15:0] == 16'h0001) begin
              out_q <= 1'b1;
              run_q <= 1'b0;
            end
          end
        end
        tmr_pkg::MODE_RATE: begin
          if (!gate) begin
            out_q <= 1'b1;
          end else if ((trig_q && armed) || ld_q) begin
            cnt_q  <= init_w;
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            out_q  <= 1'b1;
            run_q  <= 1'b1;
          end else if (run_q) begin
            if (cnt_q[15:0] == 16'h0002) begin
              out_q <= 1'b0;
              cnt_q <= cnt_dec;
            end else if (cnt_q[15:0] == 16'h0001) begin
              out_q <= 1'b1;
              cnt_q <= init_w;
            end else begin
              cnt_q <= cnt_dec;
            end
          end
        end
        tmr_pkg::MODE_SQUARE: begin
          // Binary stepping only; decimal counts are taken as binary here
          if (!gate) begin
            out_q <= 1'b1;
          end else if ((trig_q && armed) || ld_q) begin
            cnt_q  <= init_w + {16'h0000, init_q[0]};
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            out_q  <= 1'b1;
            run_q  <= 1'b1;
          end else if (run_q) begin
            if (cnt_q <= 17'h00002) begin
              out_q <= ~out_q;
              // Odd counts: N+1 for the high half, N-1 for the low half
              cnt_q <= out_q ? init_w - {16'h0000, init_q[0]}
                             : init_w + {16'h0000, init_q[0]};
            end else begin
              cnt_q <= cnt_q - 17'h00002;
            end
          end
        end
        tmr_pkg::MODE_SWSTROBE: begin
          if (ld_q) begin
            cnt_q  <= init_w;
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            run_q  <= 1'b1;
            out_q  <= 1'b1;
          end else begin
            out_q <= 1'b1;
            if (run_q && gate) begin
              cnt_q <= cnt_dec;
              if (cnt_q[15:0] == 16'h0001) begin
                out_q <= 1'b0;
                run_q <= 1'b0;
              end
            end
          end
        end
        tmr_pkg::MODE_HWSTROBE: begin
          if (trig_q && armed) begin
            cnt_q  <= init_w;
            ld_q   <= 1'b0;
            null_q <= 1'b0;
            run_q  <= 1'b1;
            out_q  <= 1'b1;
          end else begin
            out_q <= 1'b1;
            if (run_q) begin
              cnt_q <= cnt_dec;
              if (cnt_q[15:0] == 16'h0001) begin
                out_q <= 1'b0;
                run_q <= 1'b0;
              end
            end
          end
        end
        default: begin
          run_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: rtl/triple_down_counter_timer.sv
// Three-counter interval timer behind an 8-bit register port.
// Assumes register strobes are one-cycle pulses synchronous to CLK.
//
// Operation
// - Three 16-bit down counters, each with its own out; 1 clocks 2, 1/2 share a gate
// - Counter 0: 10 MHz clock, gate always on
// - Counter 1 at 10 MHz feeds counter 2
// - Gate enable of counters 1/2 at 1E
// - Trigger is gate rise; clock is pulse
// - Mode 0: load low, count, high at zero
// - Mode 1: retriggerable one-shot low pulse
// - Mode 2: divide by N, one-tick low
// - Mode 2 repeats while gate high, stops low
// - Mode 3: square wave, odd split (N+1)/2
// - Mode 3 steps count down by two
// - Mode 4: strobe low at zero, gate inhibits
// - Mode 5: gate-triggered retriggerable strobe
// - Offsets 14-16 data ports, 17 control
// - Top two bits pick counter or read-back
// - Bits 5:4 choose latch or byte order
// - Bits 3:1 choose operating mode
// - Bit 0 selects binary or decimal counting; mode 3 counts in binary either way
// - Latch holds count until fully read
// - Byte pairs alternate on a toggle
// - Read-back latches counts and queues status
`timescale 1ns/1ps
module triple_down_counter_timer (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [4:0] ADDR,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  output logic            CTR0_OUT,
  output logic            CTR1_OUT,
  output logic            CTR2_OUT
);
`include "tmr_regs.svh"

  logic [17:0]       acc_q;       // Phase accumulator for the 10 MHz source
  logic              tick_q;      // Source clock pulse
  logic              tick2_q;     // Counter 2 clock from counter 1 output
  logic              o1_prev_q;   // Counter 1 output, last cycle
  logic              gate_en_q;   // Software gate for counters 1 and 2
  logic [7:0]        rdata_q;     // Read data register
  logic              ctl_wr;      // Write to the control byte
  logic [1:0]        ctl_sel;     // Target field of that write
  logic              ctl_rb;      // Write is a read-back command
  logic [17:0]       acc_sum;     // Accumulator plus step
  logic              tick_v [3];  // Count pulse per counter
  logic              gate_v [3];  // Gate level per counter
  logic              out_v  [3];  // Output level per counter
  logic              null_v [3];  // Null count per counter
  logic [15:0]       cnt_v  [3];  // Live count per counter
  logic [7:0]        byte_v [3];  // Byte a read would return

  // Decode a mode field; the top bit is a don't-care for modes 2 and 3
  function automatic tmr_pkg::mode_type dec_mode(input logic [2:0] f);
    tmr_pkg::mode_type m;
    m = tmr_pkg::MODE_TC;
    case (f)
      3'h0:    m = tmr_pkg::MODE_TC;
      3'h1:    m = tmr_pkg::MODE_ONESHOT;
      3'h2:    m = tmr_pkg::MODE_RATE;
      3'h6:    m = tmr_pkg::MODE_RATE;
      3'h3:    m = tmr_pkg::MODE_SQUARE;
      3'h7:    m = tmr_pkg::MODE_SQUARE;
      3'h4:    m = tmr_pkg::MODE_SWSTROBE;
      default: m = tmr_pkg::MODE_HWSTROBE;
    endcase
    return m;
  endfunction

  // Control byte decode
  assign ctl_wr  = WR_STB && (ADDR == `TMR_OFS_CTRL);
  assign ctl_sel = WDATA[`TMR_SEL_HI:`TMR_SEL_LO];
  assign ctl_rb  = (ctl_sel == `TMR_SEL_RB);
  assign acc_sum = acc_q + `TMR_SRC_KHZ;

  // 10 MHz from 125 MHz: a fractional divider, so pulses jitter by one
  // system cycle while the long-run rate is exact
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_q  <= 18'h00000;
      tick_q <= 1'b0;
    end else if (acc_sum >= `TMR_SYS_KHZ) begin
      acc_q  <= acc_sum - `TMR_SYS_KHZ;
      tick_q <= 1'b1;
    end else begin
      acc_q  <= acc_sum;
      tick_q <= 1'b0;
    end
  end

  // Counter 2 counts each rising edge of the counter 1 output
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      o1_prev_q <= 1'b1;
      tick2_q   <= 1'b0;
    end else begin
      o1_prev_q <= out_v[1];
      tick2_q   <= out_v[1] & ~o1_prev_q;
    end
  end

  // Software gate register for the chained pair
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      gate_en_q <= `TMR_GATE_RST;
    end else if (WR_STB && (ADDR == `TMR_OFS_GATE)) begin
      gate_en_q <= WDATA[0];
    end
  end

  // Clock and gate wiring of the three counters
  assign tick_v[0] = tick_q;
  assign tick_v[1] = tick_q;
  assign tick_v[2] = tick2_q;
  assign gate_v[0] = 1'b1;
  assign gate_v[1] = gate_en_q;
  assign gate_v[2] = gate_en_q;

  // Per-counter register logic and counting core
  for (genvar i = 0; i < 3; i++) begin : g_ctr
    logic [1:0]        rw_q;    // Access order
    logic [2:0]        mfld_q;  // Raw mode field
    logic              bcd_q;   // Decimal counting
    tmr_pkg::mode_type mode_q;  // Decoded mode
    logic              cfgp_q;  // Config pulse toward the core
    logic [7:0]        lo_q;    // Low byte of a pair write
    logic              wflip_q; // Write byte toggle
    logic              load_q;  // Load pulse toward the core
    logic [15:0]       lval_q;  // Count toward the core
    logic [15:0]       hold_q;  // Latched count
    logic              held_q;  // Latch holds unread data
    logic              rflip_q; // Read byte toggle
    logic [7:0]        stat_q;  // Queued status byte
    logic              spend_q; // Status byte waiting
    logic              dat_wr;  // Write to this data port
    logic              dat_rd;  // Read of this data port
    logic              cfg_wr;  // Control byte for this counter
    logic              latch;   // Count latch for this counter
    logic              stat;    // Status latch for this counter
    logic              rd_last; // This read empties the latch
    logic [15:0]       src;     // Held or live count

    assign dat_wr = WR_STB && (ADDR == `TMR_OFS_CTR0 + 5'(i));
    assign dat_rd = RD_STB && (ADDR == `TMR_OFS_CTR0 + 5'(i));
    assign cfg_wr = ctl_wr && !ctl_rb && (ctl_sel == 2'(i))
                    && (WDATA[`TMR_ACC_HI:`TMR_ACC_LO] != `TMR_ACC_LATCH);
    assign latch  = ctl_wr && ((!ctl_rb && (ctl_sel == 2'(i))
                    && (WDATA[`TMR_ACC_HI:`TMR_ACC_LO] == `TMR_ACC_LATCH))
                    || (ctl_rb && !WDATA[`TMR_RB_LATCH]
                    && WDATA[`TMR_RB_PICK0 + i]));
    assign stat   = ctl_wr && ctl_rb && !WDATA[`TMR_RB_STAT]
                    && WDATA[`TMR_RB_PICK0 + i];
    assign rd_last = dat_rd && !spend_q && held_q
                     && ((rw_q != `TMR_ACC_PAIR) || rflip_q);
    assign src    = held_q ? hold_q : cnt_v[i];

    // Read byte choice: status first, then the byte order in force
    assign byte_v[i] = spend_q ? stat_q :
                       ((rw_q == `TMR_ACC_HI_B) ||
                        ((rw_q == `TMR_ACC_PAIR) && rflip_q)) ? src[15:8] : src[7:0];

    // Configuration fields of the control byte
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        rw_q   <= `TMR_ACC_RST;
        mfld_q <= 3'h0;
        bcd_q  <= 1'b0;
        mode_q <= tmr_pkg::MODE_TC;
        cfgp_q <= 1'b0;
      end else begin
        cfgp_q <= cfg_wr;
        if (cfg_wr) begin
          rw_q   <= WDATA[`TMR_ACC_HI:`TMR_ACC_LO];
          mfld_q <= WDATA[`TMR_MODE_HI:`TMR_MODE_LO];
          mode_q <= dec_mode(WDATA[`TMR_MODE_HI:`TMR_MODE_LO]);
          bcd_q  <= WDATA[`TMR_BCD_BIT];
        end
      end
    end

    // Count writes; a pair completes only on its high byte
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        lo_q    <= 8'h00;
        wflip_q <= 1'b0;
        load_q  <= 1'b0;
        lval_q  <= 16'h0000;
      end else begin
        load_q <= 1'b0;
        if (cfg_wr) begin
          wflip_q <= 1'b0; // New control byte restarts the pair
        end else if (dat_wr) begin
          case (rw_q)
            `TMR_ACC_LO_B: begin
              lval_q <= {8'h00, WDATA};
              load_q <= 1'b1;
            end
            `TMR_ACC_HI_B: begin
              lval_q <= {WDATA, 8'h00};
              load_q <= 1'b1;
            end
            `TMR_ACC_PAIR: begin
              if (!wflip_q) begin
                lo_q    <= WDATA;
                wflip_q <= 1'b1;
              end else begin
                lval_q  <= {WDATA, lo_q};
                load_q  <= 1'b1;
                wflip_q <= 1'b0;
              end
            end
            default: begin
              load_q <= 1'b0; // Latch order takes no data
            end
          endcase
        end
      end
    end

    // Hold register, read toggle and status queue; a latch wins over the last read's clear, a status read over a new status
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        hold_q  <= 16'h0000;
        held_q  <= 1'b0;
        rflip_q <= 1'b0;
        stat_q  <= 8'h00;
        spend_q <= 1'b0;
      end else if (cfg_wr) begin
        held_q  <= 1'b0;
        rflip_q <= 1'b0;
        spend_q <= 1'b0;
      end else begin
        if (dat_rd) begin
          if (spend_q) begin
            spend_q <= 1'b0;
          end else if (rw_q == `TMR_ACC_PAIR) begin
            rflip_q <= ~rflip_q;
          end
        end
        if (rd_last) begin
          held_q <= 1'b0;
        end
        // Further latches are ignored until the held value is read out
        if (latch && (!held_q || rd_last)) begin
          hold_q <= cnt_v[i];
          held_q <= 1'b1;
        end
        if (stat && !spend_q) begin
          stat_q  <= {out_v[i], null_v[i], rw_q, mfld_q, bcd_q};
          spend_q <= 1'b1;
        end
      end
    end

    tmr_core u_core (
      .clk      (CLK),
      .rst_n    (RESETN),
      .tick     (tick_v[i]),
      .gate     (gate_v[i]),
      .cfg_wr   (cfgp_q),
      .mode     (mode_q),
      .bcd      (bcd_q),
      .load     (load_q),
      .load_val (lval_q),
      .count    (cnt_v[i]),
      .out      (out_v[i]),
      .null_cnt (null_v[i])
    );
  end

  // Read data register; control byte and unmapped offsets read zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
    end else if (RD_STB) begin
      if (ADDR == `TMR_OFS_CTR0) begin
        rdata_q <= byte_v[0];
      end else if (ADDR == `TMR_OFS_CTR1) begin
        rdata_q <= byte_v[1];
      end else if (ADDR == `TMR_OFS_CTR2) begin
        rdata_q <= byte_v[2];
      end else if (ADDR == `TMR_OFS_GATE) begin
        rdata_q <= {7'h00, gate_en_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Outputs come from flip-flops in the cores and here
  assign RDATA    = rdata_q;
  assign CTR0_OUT = out_v[0];
  assign CTR1_OUT = out_v[1];
  assign CTR2_OUT = out_v[2];
endmodule

// file: bench/triple_down_counter_timer_props.sv
// Port-level assertions for the three-counter timer.
// Assumes only the top ports; bound into the design below.
`timescale 1ns/1ps
module triple_down_counter_timer_props (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic [4:0] ADDR,
  input wire logic       WR_STB,
  input wire logic       RD_STB,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic       CTR0_OUT,
  input wire logic       CTR1_OUT,
  input wire logic       CTR2_OUT
);
  logic [2:0] mode0_q; // Last mode code given to counter 0
  logic       wr0;     // A write that may disturb counter 0
  assign wr0 = WR_STB && (ADDR == 5'h14 || ADDR == 5'h17);
  // Track counter 0 mode; latch commands leave it alone
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode0_q <= 3'h0;
    end else if (WR_STB && ADDR == 5'h17 && WDATA[7:6] == 2'h0 && WDATA[5:4] != 2'h0) begin
      mode0_q <= WDATA[3:1];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Gate write followed at once by its read
  sequence gate_wr_rd;
    WR_STB && ADDR == 5'h1E ##1 RD_STB && ADDR == 5'h1E;
  endsequence
  // Low for one tick of 12 or 13 clocks
  sequence low_one_tick;
    !CTR0_OUT [*8] ##[5:6] CTR0_OUT;
  endsequence
  a_unmapped_zero: assert property (
    RD_STB && !(ADDR inside {5'h14, 5'h15, 5'h16, 5'h1E}) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_gate_upper_zero: assert property (
    RD_STB && ADDR == 5'h1E |=> RDATA[7:1] == 7'h00)
    else $error("gate upper bits not zero");
  a_gate_readback: assert property (
    gate_wr_rd |=> RDATA[0] == $past(WDATA[0], 2))
    else $error("gate bit readback wrong");
  a_rdata_holds: assert property (
    !RD_STB |=> $stable(RDATA))
    else $error("read data moved without a read");
  a_mode0_low: assert property (
    WR_STB && ADDR == 5'h17 && WDATA == 8'h10 |-> ##[1:2] !CTR0_OUT)
    else $error("mode 0 setup left output high");
  a_cfg_high: assert property (
    WR_STB && ADDR == 5'h17 && WDATA[7:4] != 4'h0 && WDATA[7:6] == 2'h0
      && WDATA[3:1] != 3'h0 |-> ##[1:2] CTR0_OUT)
    else $error("non-zero mode setup left output low");
  a_strobe_one_tick: assert property (
    $fell(CTR0_OUT) && (mode0_q[1:0] == 2'h2 || mode0_q[2:1] == 2'h2) |-> low_one_tick)
    else $error("strobe low not one tick");
  a_mode0_stays: assert property (
    mode0_q == 3'h0 && CTR0_OUT && !wr0 && !$past(wr0) && !$past(wr0, 2)
      && !$past(wr0, 3) |=> CTR0_OUT)
    else $error("mode 0 output fell without a load");
endmodule
bind triple_down_counter_timer triple_down_counter_timer_props triple_down_counter_timer_props_inst (
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
  .WDATA(WDATA), .RDATA(RDATA), .CTR0_OUT(CTR0_OUT), .CTR1_OUT(CTR1_OUT),
  .CTR2_OUT(CTR2_OUT));

// file: bench/triple_down_counter_timer_tb.sv
// Self-checking bench: bus tasks, integer model, timing runs.
// Assumes the design alone on one clock; bench drives every port.
`timescale 1ns/1ps
module triple_down_counter_timer_tb;
  logic       CLK, RESETN, WR_STB, RD_STB;  // Clock, reset, strobes
  logic [4:0] ADDR;                         // Byte offset
  logic [7:0] WDATA, RDATA, b;              // Bus data, scratch
  logic       CTR0_OUT, CTR1_OUT, CTR2_OUT; // Counter outputs
  int         n_fail, compares, n, m, k;    // Tallies and scratch
  logic [7:0] expq[$];                      // Model of queued read bytes
  triple_down_counter_timer triple_down_counter_timer_inst (
    .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .WDATA(WDATA), .RDATA(RDATA), .CTR0_OUT(CTR0_OUT), .CTR1_OUT(CTR1_OUT),
    .CTR2_OUT(CTR2_OUT));
  // 125 MHz clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict; the only place the run ends
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Byte write; strobe stays up until the next task lowers it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
  endtask
  // Byte read; data taken the cycle after the strobe
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    ADDR <= a;
    RD_STB <= 1'b1;
    WR_STB <= 1'b0;
    @(posedge CLK);
    RD_STB <= 1'b0;
    @(negedge CLK);
    chk(RDATA, exp);
    @(posedge CLK);
  endtask
  task automatic idle(input int c);
    WR_STB <= 1'b0;
    repeat (c) @(posedge CLK);
  endtask
  // Control byte then a low/high count pair
  task automatic load(input int c, input logic [7:0] ctl, input int v);
    wr(5'h17, ctl);
    wr(5'(20 + c), 8'(v));
    wr(5'(20 + c), 8'(v >> 8));
  endtask
  function automatic logic outv(input int i);
    return i == 0 ? CTR0_OUT : (i == 1 ? CTR1_OUT : CTR2_OUT);
  endfunction
  // Time one low run and the high run after it; a tick is 12 or 13 clocks
  task automatic meas(input int i, input int lo, input int hi);
    int a, h;
    WR_STB <= 1'b0;
    a = 0;
    h = 0;
    while (outv(i) !== 1'b0 && a < 4000) begin
      @(negedge CLK);
      a++;
    end
    a = 0;
    while (outv(i) === 1'b0 && a < 4000) begin
      @(negedge CLK);
      a++;
    end
    while (outv(i) === 1'b1 && h < 4000) begin
      @(negedge CLK);
      h++;
    end
    chk({7'h0, a >= 12 * lo - 1 && a <= 13 * lo + 1}, 8'h01);
    // Zero high ticks means no repeat within the window
    chk({7'h0, hi == 0 ? h == 4000 : h >= 12 * hi - 1 && h <= 13 * hi + 1}, 8'h01);
    // Return in a high phase so the next write cuts no low pulse short
    a = 0;
    while (hi != 0 && outv(i) === 1'b0 && a < 4000) begin
      @(negedge CLK);
      a++;
    end
    @(posedge CLK);
  endtask
  // Cut a hang short
  initial begin
    #400000;
    n_fail++;
    stop_test;
  end
  initial begin
    RESETN = 1'b0;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    ADDR = 5'h00;
    WDATA = 8'h00;
    n_fail = 0;
    compares = 0;
    n = $urandom(32'hBEB501FF);
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    // Control and unmapped places read zero; gate bit reads back
    wr(5'h17, 8'h10);
    rdchk(5'h17, 8'h00);
    rdchk(5'h03, 8'h00);
    b = 8'($urandom);
    wr(5'h1E, b);
    rdchk(5'h1E, {7'h0, b[0]});
    wr(5'h1E, 8'h00);
    // Counter 1 held by its low gate, so its count is exact
    n = 2 + $urandom % 65534;
    load(1, 8'h70, n);
    idle(40);
    wr(5'h17, 8'h40);
    rdchk(5'h15, 8'(n));
    rdchk(5'h15, 8'(n >> 8));
    wr(5'h17, 8'hC4);
    expq = '{8'h30, 8'(n), 8'(n >> 8)};
    while (expq.size() > 0) rdchk(5'h15, expq.pop_front());
    // Single-byte orders, low then high
    for (m = 1; m < 3; m++) begin
      b = 8'(2 + $urandom % 250);
      wr(5'h17, {2'h1, 2'(m), 4'h0});
      wr(5'h15, b);
      idle(40);
      wr(5'h17, 8'h40);
      rdchk(5'h15, b);
    end
    // Every mode code with a random decimal bit, seen through status
    for (m = 0; m < 8; m++) begin
      b = {2'h1, 2'h3, 3'(m), 1'($urandom)};
      wr(5'h17, b);
      idle(3);
      wr(5'h17, 8'hE4);
      // Status keeps the raw mode field; null stays set with no count written
      rdchk(5'h15, {m != 0, 1'b1, b[5:0]});
    end
    // Rate mode by both codes, then odd square wave, then strobe
    for (m = 0; m < 2; m++) begin
      n = 2 + $urandom % 8;
      load(0, m == 0 ? 8'h34 : 8'h3C, n);
      meas(0, 1, n - 1);
    end
    n = 3 + 2 * ($urandom % 4);
    load(0, 8'h36, n);
    meas(0, (n - 1) / 2, (n + 1) / 2);
    load(0, 8'h38, n);
    meas(0, 1, 0);
    // Mode 0 on counter 0: low from the load, high once the count runs out
    load(0, 8'h30, n);
    idle(2);
    @(negedge CLK);
    chk({7'h0, CTR0_OUT}, 8'h00);
    repeat (13 * n + 30) @(negedge CLK);
    chk({7'h0, CTR0_OUT}, 8'h01);
    @(posedge CLK);
    // Chained divider, gated on, then gated off
    n = 2 + $urandom % 3;
    load(1, 8'h74, 3);
    load(2, 8'hB4, n);
    wr(5'h1E, 8'h01);
    meas(2, 3, 3 * (n - 1));
    wr(5'h1E, 8'h00);
    idle(4);
    k = 0;
    repeat (500) begin
      @(negedge CLK);
      if (CTR2_OUT !== 1'b1) k++;
    end
    chk(8'(k), 8'h00);
    // Gate-triggered one-shot and strobe on counter 1
    load(1, 8'h72, n);
    wr(5'h1E, 8'h01);
    meas(1, n, 0);
    wr(5'h1E, 8'h00);
    load(1, 8'h7A, n);
    wr(5'h1E, 8'h01);
    meas(1, 1, 0);
    stop_test;
  end
endmodule
